// [design/jtag_debug_event_port.sv]
/*
 Test access port, debug-command path and open-drain debug-event pin.
 Assumes the test clock is far slower than clk_in so its edges are found
 by oversampling, and the core answers stop and save requests by handshake.
*/
`include "jtag_debug_defs.svh"
`default_nettype none

module jtag_debug_event_port
	import jtag_debug_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic tck_in,
	input wire logic tms_in,
	input wire logic tdi_in,
	input wire logic trst_n_in,
	output logic tdo_out,
	output logic tdo_oe_out,
	input wire logic debug_event_n_in,
	output logic debug_event_n_out,
	output logic debug_event_n_oe_out,
	input wire logic breakpoint_in,
	input wire logic core_instr_done_in,
	input wire logic core_saved_in,
	output logic core_stop_out,
	output logic core_save_out,
	output logic cmd_valid_out,
	output logic [`DR_W-1:0] cmd_data_out,
	input wire logic cmd_ready_in
);
	// ==========================================================
	// Reset release and pin synchronisers
	logic [1:0] rst_pipe_q;
	logic rst_n, tap_rst_n;
	logic [3:0] meta_q, sync_q;
	logic tck_s, tms_s, tdi_s, de_s, tck_prev_q, tck_rise, tck_fall;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_pipe_q <= 2'h0;
		end else begin
			rst_pipe_q <= {rst_pipe_q[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe_q[1];
	assign tap_rst_n = rst_n && trst_n_in;

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			// Idle pin levels: test clock low, the rest pulled up, so no false edge
			meta_q <= 4'hE;
			sync_q <= 4'hE;
			tck_prev_q <= 1'b0;
		end else begin
			meta_q <= {debug_event_n_in, tdi_in, tms_in, tck_in};
			sync_q <= meta_q;
			tck_prev_q <= sync_q[0];
		end
	end
	assign {de_s, tdi_s, tms_s, tck_s} = sync_q;
	assign tck_rise = tck_s && !tck_prev_q;
	assign tck_fall = !tck_s && tck_prev_q;

	// ==========================================================
	// Test controller
	function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
		case (s)
			tlr: tap_next = m ? tlr : rti;
			rti: tap_next = m ? sel_dr : rti;
			sel_dr: tap_next = m ? sel_ir : cap_dr;
			cap_dr: tap_next = m ? ex1_dr : sh_dr;
			sh_dr: tap_next = m ? ex1_dr : sh_dr;
			ex1_dr: tap_next = m ? upd_dr : pa_dr;
			pa_dr: tap_next = m ? ex2_dr : pa_dr;
			ex2_dr: tap_next = m ? upd_dr : sh_dr;
			upd_dr: tap_next = m ? sel_dr : rti;
			sel_ir: tap_next = m ? tlr : cap_ir;
			cap_ir: tap_next = m ? ex1_ir : sh_ir;
			sh_ir: tap_next = m ? ex1_ir : sh_ir;
			ex1_ir: tap_next = m ? upd_ir : pa_ir;
			pa_ir: tap_next = m ? ex2_ir : pa_ir;
			ex2_ir: tap_next = m ? upd_ir : sh_ir;
			upd_ir: tap_next = m ? sel_dr : rti;
			default: tap_next = tlr;
		endcase
	endfunction

	tap_state_t tap_q, tap_d;
	logic [`IR_W-1:0] ir_q, ir_d, ir_sh_q, ir_sh_d;
	logic [`DR_W-1:0] dr_sh_q, dr_sh_d;
	logic byp_q, byp_d, tdo_q, tdo_d, oe_q, oe_d;
	logic upd_data_q, upd_data_d, go_q, go_d, halt_req_q, halt_req_d, dropped_q, dropped_d;
	logic halted;

	stream_if #(.W(`DR_W)) fill ();
	stream_if #(.W(`DR_W)) drain ();

	always_comb begin
		tap_d = tap_q;
		ir_d = ir_q;
		ir_sh_d = ir_sh_q;
		dr_sh_d = dr_sh_q;
		byp_d = byp_q;
		tdo_d = tdo_q;
		oe_d = oe_q;
		upd_data_d = 1'b0;
		go_d = 1'b0;
		halt_req_d = 1'b0;
		// Set beats clear: a refused word in the capture cycle stays flagged
		dropped_d = dropped_q || (upd_data_q && !(fill.ready && halted));
		if (tck_rise) begin
			tap_d = tap_next(tap_q, tms_s);
			case (tap_q)
				tlr: ir_d = `IR_BYPASS;
				cap_ir: ir_sh_d = `IR_CAPTURE;
				sh_ir: ir_sh_d = {tdi_s, ir_sh_q[`IR_W-1:1]};
				upd_ir: begin
					ir_d = ir_sh_q;
					go_d = (ir_sh_q == `IR_GO);
					halt_req_d = (ir_sh_q == `IR_HALT);
				end
				cap_dr: begin
					dr_sh_d = {halted, dropped_q, 6'h00};
					byp_d = 1'b0;
					if (ir_q == `IR_DATA) begin
						dropped_d = upd_data_q && !(fill.ready && halted);
					end
				end
				sh_dr: begin
					if (ir_q == `IR_DATA) begin
						dr_sh_d = {tdi_s, dr_sh_q[`DR_W-1:1]};
					end else begin
						byp_d = tdi_s;
					end
				end
				upd_dr: upd_data_d = (ir_q == `IR_DATA);
				default: ;
			endcase
		end
		if (tck_fall) begin
			oe_d = (tap_q == sh_ir) || (tap_q == sh_dr);
			if (tap_q == sh_ir) begin
				tdo_d = ir_sh_q[0];
			end else begin
				tdo_d = (ir_q == `IR_DATA) ? dr_sh_q[0] : byp_q;
			end
		end
	end

	// is the controller's duty; without it the rst_n release still starts in reset
	always_ff @(posedge clk_in or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			tap_q <= tlr;
			ir_q <= `IR_BYPASS;
			ir_sh_q <= '0;
			dr_sh_q <= '0;
			byp_q <= 1'b0;
			tdo_q <= 1'b0;
			oe_q <= 1'b0;
			upd_data_q <= 1'b0;
			go_q <= 1'b0;
			halt_req_q <= 1'b0;
			dropped_q <= 1'b0;
		end else begin
			tap_q <= tap_d;
			ir_q <= ir_d;
			ir_sh_q <= ir_sh_d;
			dr_sh_q <= dr_sh_d;
			byp_q <= byp_d;
			tdo_q <= tdo_d;
			oe_q <= oe_d;
			upd_data_q <= upd_data_d;
			go_q <= go_d;
			halt_req_q <= halt_req_d;
			dropped_q <= dropped_d;
		end
	end
	assign tdo_out = tdo_q;
	assign tdo_oe_out = oe_q;

	// ==========================================================
	// Command buffer toward the halted core
	assign fill.valid = upd_data_q && halted;
	assign fill.data = dr_sh_q;

	word_fifo #(.W(`DR_W), .DEPTH(`FIFO_DEPTH)) cmd_fifo (
		.clk_in(clk_in),
		.rst_n_in(rst_n),
		.wr(fill),
		.rd(drain)
	);

	logic cmd_valid_q, cmd_valid_d;
	logic [`DR_W-1:0] cmd_data_q, cmd_data_d;
	assign drain.ready = !cmd_valid_q || cmd_ready_in;

	always_comb begin
		cmd_valid_d = cmd_valid_q;
		cmd_data_d = cmd_data_q;
		if (drain.ready) begin
			cmd_valid_d = drain.valid;
			cmd_data_d = drain.data;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			cmd_valid_q <= 1'b0;
			cmd_data_q <= '0;
		end else begin
			cmd_valid_q <= cmd_valid_d;
			cmd_data_q <= cmd_data_d;
		end
	end
	assign cmd_valid_out = cmd_valid_q;
	assign cmd_data_out = cmd_data_q;

	// ==========================================================
	// Debug entry and event pulse
	dbg_state_t dbg_q, dbg_d;
	logic [1:0] evt_q, evt_d;
	logic de_oe_q, de_oe_d, stop_q, stop_d, save_q, save_d, ext_req;

	// Own drive is masked only while de_oe_q is high; its echo lasts two cycles longer and re-triggers entry if the core has resumed by then
	assign ext_req = !de_s && !de_oe_q;
	assign halted = (dbg_q == dbg_halt);

	always_comb begin
		dbg_d = dbg_q;
		evt_d = evt_q;
		de_oe_d = de_oe_q;
		if (de_oe_q) begin
			if (evt_q == 2'h0) begin
				de_oe_d = 1'b0;
			end else begin
				evt_d = evt_q - 1'b1;
			end
		end
		case (dbg_q)
			dbg_run: if (ext_req || halt_req_q || breakpoint_in) begin
				dbg_d = dbg_finish;
			end
			dbg_finish: if (core_instr_done_in) begin
				dbg_d = dbg_save;
			end
			dbg_save: if (core_saved_in) begin
				dbg_d = dbg_halt;
				de_oe_d = 1'b1;
				evt_d = 2'(`EVT_CYCLES - 1);
			end
			dbg_halt: if (go_q) begin
				dbg_d = dbg_run;
			end
			default: dbg_d = dbg_run;
		endcase
		stop_d = (dbg_d != dbg_run);
		save_d = (dbg_d == dbg_save);
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			dbg_q <= dbg_run;
			evt_q <= 2'h0;
			de_oe_q <= 1'b0;
			stop_q <= 1'b0;
			save_q <= 1'b0;
		end else begin
			dbg_q <= dbg_d;
			evt_q <= evt_d;
			de_oe_q <= de_oe_d;
			stop_q <= stop_d;
			save_q <= save_d;
		end
	end
	assign debug_event_n_oe_out = de_oe_q;
	assign debug_event_n_out = 1'b0;
	assign core_stop_out = stop_q;
	assign core_save_out = save_q;

	// ==========================================================
	// Checks
	mode_advance_a: assert property (@(posedge clk_in) disable iff (!tap_rst_n)
		tck_rise && tap_q == sh_dr && tms_s |=> tap_q == ex1_dr)
		else $error("mode select did not leave shift-DR");
	data_sample_a: assert property (@(posedge clk_in) disable iff (!tap_rst_n)
		tck_rise && tap_q == sh_ir |=> ir_sh_q[`IR_W-1] == $past(tdi_s))
		else $error("test data not shifted into instruction");
	tdo_drive_a: assert property (@(posedge clk_in) disable iff (!tap_rst_n)
		$rose(tdo_oe_out) |-> $past(tap_q == sh_ir || tap_q == sh_dr))
		else $error("test data out enabled outside shift");
	tdo_falling_a: assert property (@(posedge clk_in) disable iff (!tap_rst_n)
		$changed(tdo_out) |-> $past(tck_fall))
		else $error("test data out changed off falling edge");
	trst_init_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		!trst_n_in |-> tap_q == tlr && !tdo_oe_out)
		else $error("test reset did not initialise controller");
	tdo_float_a: assert property (@(posedge clk_in) disable iff (!tap_rst_n)
		(tap_q == rti) [*8] |-> !tdo_oe_out)
		else $error("test data out driven while idle");
	entry_order_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		dbg_q == dbg_finish && !core_instr_done_in |=> dbg_q == dbg_finish && core_stop_out && !core_save_out)
		else $error("debug entry skipped instruction completion");
	halt_wait_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		halted && !go_q |=> halted && core_stop_out)
		else $error("halted core left debug without command");
	event_low_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		debug_event_n_oe_out |-> !debug_event_n_out && halted)
		else $error("debug event driven other than low in debug");
	event_width_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		$rose(debug_event_n_oe_out) |-> debug_event_n_oe_out [*3] ##1 !debug_event_n_oe_out)
		else $error("debug event pulse not three cycles");

	enter_halt_c: cover property (@(posedge clk_in) disable iff (!rst_n) $rose(halted));
	cmd_push_c: cover property (@(posedge clk_in) disable iff (!rst_n) fill.valid && fill.ready);
	resume_c: cover property (@(posedge clk_in) disable iff (!rst_n) halted && go_q);
	drop_c: cover property (@(posedge clk_in) disable iff (!rst_n) $rose(dropped_q));
endmodule

`default_nettype wire

// [design/jtag_debug_defs.svh]
/*
 Constants of the test access port and the debug-event logic.
 Assumes it is included by its bare name wherever a value is needed.
*/
`ifndef JTAG_DEBUG_DEFS_SVH
`define JTAG_DEBUG_DEFS_SVH

// ==========================================================
// Scan registers
`define IR_W 4
`define DR_W 8
`define IR_CAPTURE 4'h1
`define IR_DATA 4'h1
`define IR_GO 4'h2
`define IR_HALT 4'h3
`define IR_BYPASS 4'hF

// ==========================================================
// Debug event and buffering
`define EVT_CYCLES 3
`define FIFO_DEPTH 4

`endif

// [design/jtag_debug_pkg.sv]
/*
 Types shared by the test port design: controller and debug states.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package jtag_debug_pkg;
	typedef enum logic [3:0] {
		tlr, rti, sel_dr, cap_dr, sh_dr, ex1_dr, pa_dr, ex2_dr, upd_dr,
		sel_ir, cap_ir, sh_ir, ex1_ir, pa_ir, ex2_ir, upd_ir
	} tap_state_t;

	typedef enum logic [1:0] {
		dbg_run, dbg_finish, dbg_save, dbg_halt
	} dbg_state_t;
endpackage

`default_nettype wire

// [design/stream_if.sv]
/*
 Valid/ready word stream between the port logic and its command buffer.
 Assumes both ends sit on the same clock.
*/
`default_nettype none

interface stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// [design/word_fifo.sv]
/*
 Small synchronous FIFO with valid/ready on both sides.
 Assumes one clock and an active-low asynchronous reset already synchronised.
*/
`default_nettype none

module word_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	stream_if.snk wr,
	stream_if.src rd
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0] mem [DEPTH];
	logic [PW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
	logic [CW-1:0] count_q, count_d;
	logic push, pop;

	assign wr.ready = (count_q != CW'(DEPTH));
	assign rd.valid = (count_q != '0);
	assign rd.data = mem[rptr_q];
	assign push = wr.valid && wr.ready;
	assign pop = rd.valid && rd.ready;

	always_comb begin
		wptr_d = wptr_q;
		rptr_d = rptr_q;
		count_d = count_q;
		if (push) begin
			wptr_d = (wptr_q == PW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
		end
		if (pop) begin
			rptr_d = (rptr_q == PW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
		end
		if (push && !pop) begin
			count_d = count_q + 1'b1;
		end else if (pop && !push) begin
			count_d = count_q - 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wptr_q <= '0;
			rptr_q <= '0;
			count_q <= '0;
		end else begin
			wptr_q <= wptr_d;
			rptr_q <= rptr_d;
			count_q <= count_d;
		end
	end

	// Storage needs no reset; valid never exposes an unwritten slot
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wptr_q] <= wr.data;
		end
	end
endmodule

`default_nettype wire

// [testbench/jtag_host_model.sv]
/*
 Model of the external test controller: test clock, mode, data, test reset
 and a pull-down on the debug-event line.
 Assumes one caller at a time; the test clock rests low between frames.
*/
`default_nettype none

module jtag_host_model (
	output logic tck_out,
	output logic tms_out,
	output logic tdi_out,
	output logic trst_n_out,
	output logic req_n_out,
	input wire logic tdo_in
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b1;
		trst_n_out = 1'b1;
		req_n_out = 1'b1;
	end

	// ==========
	// Bit and frame tasks
	// Uneven halves keep the test clock off the system clock's phase
	task automatic bit_io(input logic m, input logic d, output logic o);
		tms_out = m;
		tdi_out = d;
		#167;
		tck_out = 1'b1;
		o = tdo_in;
		#153;
		tck_out = 1'b0;
	endtask

	task automatic pulse_reset;
		trst_n_out = 1'b0;
		#200;
		trst_n_out = 1'b1;
	endtask

	task automatic request(input int t);
		req_n_out = 1'b0;
		#t;
		req_n_out = 1'b1;
	endtask

	// From idle through capture, n shifts, update and back to idle
	task automatic scan(input logic ir, input logic [7:0] din, input int n, output logic [7:0] dout);
		logic o;
		dout = 8'h00;
		bit_io(1'b1, 1'b1, o);
		if (ir) begin
			bit_io(1'b1, 1'b1, o);
		end
		bit_io(1'b0, 1'b1, o);
		bit_io(1'b0, 1'b1, o);
		for (int i = 0; i < n; i++) begin
			bit_io(i == n - 1, din[i], o);
			dout[i] = o;
		end
		bit_io(1'b1, 1'b1, o);
		bit_io(1'b0, 1'b1, o);
	endtask
endmodule

`default_nettype wire

// [testbench/testbench.sv]
/*
 Self-checking bench of the test port and debug-event logic.
 Assumes the host model drives the test pins and a small core model answers stop and save.
*/
`default_nettype none

`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
	$display("[FAIL] %s expected %h seen %h", what, exp, got); end end

module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk = 0, rst_n = 0, bkpt = 0, core_done = 0, core_saved = 0, ready = 0, saw_save = 0;
	wire tck, tms, tdi, trst_n, req_n, tdo, tdo_oe, evt_out, evt_oe, stop, save, cvalid;
	wire [7:0] cdata;
	wire tdo_line = tdo_oe ? tdo : 1'bz;
	// Open-drain line with pull-up
	wire evt_line = (~req_n | (evt_oe & ~evt_out)) ? 1'b0 : 1'b1;
	int mismatches = 0, comparisons = 0;

	jtag_host_model host (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .trst_n_out(trst_n),
		.req_n_out(req_n), .tdo_in(tdo_line));

	jtag_debug_event_port uut (.clk_in(clk), .rst_n_in(rst_n), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
		.trst_n_in(trst_n), .tdo_out(tdo), .tdo_oe_out(tdo_oe), .debug_event_n_in(evt_line),
		.debug_event_n_out(evt_out), .debug_event_n_oe_out(evt_oe), .breakpoint_in(bkpt),
		.core_instr_done_in(core_done), .core_saved_in(core_saved), .core_stop_out(stop),
		.core_save_out(save), .cmd_valid_out(cvalid), .cmd_data_out(cdata), .cmd_ready_in(ready));

	initial begin
		forever #20 clk = ~clk;
	end

	// ==========
	// Core stand-in: finishes and saves one cycle after each request
	always @(posedge clk) begin
		core_done <= stop;
		core_saved <= save;
		if (save === 1'b1) saw_save <= 1'b1;
	end

	// ==========
	// Helpers
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic tick;
		@(posedge clk);
		#2;
	endtask

	task automatic ir(input logic [3:0] v);
		logic [7:0] o;
		host.scan(1'b1, {4'h0, v}, 4, o);
		`CHK("ir capture", 8'h01, o)
	endtask

	task automatic dr(input logic [7:0] v, input logic [7:0] cap);
		logic [7:0] o;
		host.scan(1'b0, v, 8, o);
		`CHK("dr capture", cap, o)
	endtask

	task automatic entry;
		int n;
		n = 0;
		while (evt_oe !== 1'b1 && n < 60) begin
			tick();
			n++;
		end
		if (n == 60) begin
			mismatches++;
			$display("[FAIL] entry wait expected 1 seen 0");
			final_report();
		end
		`CHK("saved first", 1'b1, saw_save)
		n = 0;
		while (evt_oe === 1'b1 && n < 8) begin
			`CHK("line low", 1'b0, evt_line)
			n++;
			tick();
		end
		`CHK("pulse cycles", 3, n)
		`CHK("line released", 1'b1, evt_line)
		repeat (10) tick();
		`CHK("still halted", 1'b1, stop)
		saw_save = 1'b0;
	endtask

	task automatic resume;
		ir(4'h2);
		repeat (4) tick();
		`CHK("resumed", 1'b0, stop)
	endtask

	// ==========
	// Scenarios
	task automatic t_reset;
		logic o;
		logic [3:0] path;
		path = 4'b0011;
		host.pulse_reset();
		host.bit_io(1'b0, 1'b1, o);
		for (int i = 0; i < 4; i++) begin
			host.bit_io(path[i], 1'b1, o);
		end
		repeat (6) tick();
		`CHK("oe in shift", 1'b1, tdo_oe)
		`CHK("first ir bit", 1'b1, tdo)
		host.pulse_reset();
		`CHK("oe after reset", 1'b0, tdo_oe)
		`CHK("no event", 1'b0, evt_oe)
		host.bit_io(1'b0, 1'b1, o);
		$display("reset test done");
	endtask

	task automatic t_drop;
		ir(4'h1);
		dr(8'h3C, 8'h00);
		dr(8'h00, 8'h40);
		`CHK("no command", 1'b0, cvalid)
		$display("drop test done");
	endtask

	task automatic t_fill;
		int k;
		ir(4'h3);
		entry();
		ir(4'h1);
		for (int i = 0; i < 6; i++) begin
			dr(8'h10 + 8'(i), (i == 0) ? 8'hC0 : 8'h80);
		end
		dr(8'h00, 8'hC0);
		`CHK("held valid", 1'b1, cvalid)
		`CHK("held data", 8'h10, cdata)
		ready = 1'b1;
		k = 0;
		repeat (20) begin
			if (cvalid === 1'b1 && k < 5) begin
				`CHK("drained", 8'h10 + 8'(k), cdata)
				k++;
			end
			tick();
		end
		ready = 1'b0;
		`CHK("drained count", 5, k)
		resume();
		$display("halt and buffer test done");
	endtask

	task automatic t_ext;
		host.request(160);
		entry();
		resume();
		bkpt = 1'b1;
		tick();
		bkpt = 1'b0;
		entry();
		resume();
		$display("request and breakpoint test done");
	endtask

	initial begin
		repeat (3) @(posedge clk);
		#2;
		rst_n = 1'b1;
		repeat (6) tick();
		t_reset();
		t_drop();
		t_fill();
		t_ext();
		final_report();
	end

	initial begin
		#3000000;
		mismatches++;
		$display("[FAIL] run time expected done seen hang");
		final_report();
	end
endmodule

`default_nettype wire
